// ==== common/lti_pkg.sv ====
// Constants, field layout and types shared by the light threshold interrupt logic.
`default_nettype none

package lti_pkg;

   // =====================================================================
   // Register map
   // =====================================================================
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 16;
   localparam logic [7:0]  RESULT_ADDR   = 8'h00;
   localparam logic [7:0]  CFG_ADDR      = 8'h01;
   localparam logic [7:0]  LOW_ADDR      = 8'h02;
   localparam logic [7:0]  HIGH_ADDR     = 8'h03;

   // =====================================================================
   // Configuration field positions
   // =====================================================================
   localparam int          CFG_MODE_LSB  = 9;
   localparam int          CFG_PIN_BIT   = 8;
   localparam int          CFG_READY_BIT = 7;
   localparam int          CFG_FH_BIT    = 6;
   localparam int          CFG_FL_BIT    = 5;
   localparam int          CFG_LATCH_BIT = 4;
   localparam int          CFG_POL_BIT   = 3;
   localparam int          CFG_FC_LSB    = 0;
   localparam int          LOW_TOP_LSB   = 14;

   // =====================================================================
   // Codes and reset values
   // =====================================================================
   localparam logic [1:0]  MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0]  EOC_CODE      = 2'h3;
   localparam logic [1:0]  RST_MODE      = 2'h0;
   localparam logic        RST_LATCH     = 1'h1;
   localparam logic        RST_POL       = 1'h0;
   localparam logic [1:0]  RST_FC        = 2'h0;
   localparam logic [15:0] RST_LOW       = 16'h0000;
   localparam logic [15:0] RST_HIGH      = 16'hffff;
   localparam logic [15:0] RST_RESULT    = 16'h0000;
   localparam logic [3:0]  CNT_MAX       = 4'h8;

   typedef struct packed {
      logic [1:0] mode;
      logic       latch;
      logic       polarity;
      logic [1:0] fault_count;
   } lti_cfg_t;

   localparam lti_cfg_t    RST_CFG = '{mode: RST_MODE, latch: RST_LATCH,
                                       polarity: RST_POL, fault_count: RST_FC};

   // Fault count field 0..3 selects 1, 2, 4 or 8 consecutive faults.
   function automatic logic [3:0] faults_needed(input logic [1:0] code);
      faults_needed = 4'h1 << code;
   endfunction : faults_needed

endpackage : lti_pkg

`default_nettype wire

// ==== logic/lti_fault_counter.sv ====
// Consecutive same-direction fault counter for the threshold comparison.
`default_nettype none
`timescale 1ns/100ps

module lti_fault_counter
   import lti_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        done_i,
   input  wire logic [15:0] result_i,
   input  wire logic [15:0] high_i,
   input  wire logic [15:0] low_i,
   input  wire logic [1:0]  fault_code_i,
   output logic             trip_high_o,
   output logic             trip_low_o
);

   logic [3:0] count;
   logic       dir_high;
   logic [3:0] next_count;
   logic       next_dir_high;
   logic       above;
   logic       below;
   logic [3:0] needed;

   assign above  = result_i > high_i;
   assign below  = result_i < low_i;
   assign needed = faults_needed(fault_code_i);

   // =====================================================================
   // Counting
   // =====================================================================
   always_comb begin
      next_count    = count;
      next_dir_high = dir_high;
      if (done_i) begin
         if (above) begin
            next_dir_high = 1'b1;
            next_count    = (dir_high && count != 4'h0) ? count + 4'h1 : 4'h1;
         end else if (below) begin
            next_dir_high = 1'b0;
            next_count    = (!dir_high && count != 4'h0) ? count + 4'h1 : 4'h1;
         end else begin
            next_count = 4'h0;
         end
         if (next_count > CNT_MAX) begin
            next_count = CNT_MAX;
         end
      end
   end

   // Trips fire on each completion that meets the configured run length.
   assign trip_high_o = done_i && above && (next_count >= needed);
   assign trip_low_o  = done_i && !above && below && (next_count >= needed);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count    <= 4'h0;
         dir_high <= 1'b0;
      end else begin
         count    <= next_count;
         dir_high <= next_dir_high;
      end
   end

   // =====================================================================
   // Checks
   // =====================================================================
   chk_restart_in_range: assert property (@(posedge clk_i) disable iff (rst_i)
      done_i && !above && !below |=> count == 4'h0)
      else $error("fault counter did not restart on in-range result");

   chk_trip_at_count: assert property (@(posedge clk_i) disable iff (rst_i)
      done_i && above && dir_high && count != 4'h0 && count + 4'h1 == needed |-> trip_high_o)
      else $error("high trip missing at configured fault count");

   chk_no_early_trip: assert property (@(posedge clk_i) disable iff (rst_i)
      trip_low_o |=> !dir_high && count >= $past(needed))
      else $error("low trip before enough faults");

endmodule : lti_fault_counter

`default_nettype wire

// ==== logic/lti_top.sv ====
// Interrupt reporting logic: flags, conversion ready and open-drain interrupt pin.
`default_nettype none
`timescale 1ns/100ps

module lti_top
   import lti_pkg::*;
(
   input  wire logic        CORE_CLK_I,
   input  wire logic        RST_I,
   input  wire logic [7:0]  REG_ADDR_I,
   input  wire logic [15:0] REG_WDATA_I,
   input  wire logic        REG_WR_I,
   input  wire logic        REG_RD_I,
   output logic      [15:0] REG_RDATA_O,
   input  wire logic        CONV_DONE_I,
   input  wire logic [15:0] CONV_RESULT_I,
   input  wire logic        ALERT_RESP_I,
   input  wire logic        INT_I,
   output logic             INT_O,
   output logic             INT_OE_O
);

   // =====================================================================
   // State
   // =====================================================================
   lti_cfg_t    cfg;
   logic [15:0] low_limit;
   logic [15:0] high_limit;
   logic [15:0] result;
   logic        flag_high;
   logic        flag_low;
   logic        conv_ready;
   logic        int_active;
   logic        int_oe;
   logic        int_meta;
   logic        int_sync;
   logic [15:0] rdata;

   lti_cfg_t    next_cfg;
   logic [15:0] next_low_limit;
   logic [15:0] next_high_limit;
   logic [15:0] next_result;
   logic        next_flag_high;
   logic        next_flag_low;
   logic        next_conv_ready;
   logic        next_int_active;
   logic        next_int_oe;
   logic        next_int_meta;
   logic        next_int_sync;
   logic [15:0] next_rdata;

   logic        cfg_rd;
   logic        cfg_wr;
   logic        low_wr;
   logic        high_wr;
   logic        run_wr;
   logic        eoc;
   logic        trip_high;
   logic        trip_low;
   logic [1:0]  low_limit_top_bits;
   logic [15:0] cfg_word;

   assign cfg_rd  = REG_RD_I && (REG_ADDR_I == CFG_ADDR);
   assign cfg_wr  = REG_WR_I && (REG_ADDR_I == CFG_ADDR);
   assign low_wr  = REG_WR_I && (REG_ADDR_I == LOW_ADDR);
   assign high_wr = REG_WR_I && (REG_ADDR_I == HIGH_ADDR);
   assign run_wr  = cfg_wr && (REG_WDATA_I[CFG_MODE_LSB +: 2] != MODE_SHUTDOWN);

   assign low_limit_top_bits = low_limit[LOW_TOP_LSB +: 2];
   assign eoc                = (low_limit_top_bits == EOC_CODE);

   // =====================================================================
   // Threshold comparison
   // =====================================================================
   lti_fault_counter u_fault_counter (
      .clk_i        (CORE_CLK_I),
      .rst_i        (RST_I),
      .done_i       (CONV_DONE_I),
      .result_i     (CONV_RESULT_I),
      .high_i       (high_limit),
      .low_i        (low_limit),
      .fault_code_i (cfg.fault_count),
      .trip_high_o  (trip_high),
      .trip_low_o   (trip_low)
   );

   // =====================================================================
   // Register read data
   // =====================================================================
   always_comb begin
      cfg_word                          = 16'h0000;
      cfg_word[CFG_MODE_LSB +: 2]       = cfg.mode;
      cfg_word[CFG_PIN_BIT]             = int_sync;
      cfg_word[CFG_READY_BIT]           = conv_ready;
      cfg_word[CFG_FH_BIT]              = flag_high;
      cfg_word[CFG_FL_BIT]              = flag_low;
      cfg_word[CFG_LATCH_BIT]           = cfg.latch;
      cfg_word[CFG_POL_BIT]             = cfg.polarity;
      cfg_word[CFG_FC_LSB +: 2]         = cfg.fault_count;
   end

   always_comb begin
      next_rdata = 16'h0000;
      if (REG_RD_I) begin
         if (REG_ADDR_I == RESULT_ADDR) begin
            next_rdata = result;
         end else if (REG_ADDR_I == CFG_ADDR) begin
            next_rdata = cfg_word;
         end else if (REG_ADDR_I == LOW_ADDR) begin
            next_rdata = low_limit;
         end else if (REG_ADDR_I == HIGH_ADDR) begin
            next_rdata = high_limit;
         end else begin
            next_rdata = 16'h0000;
         end
      end
   end

   // =====================================================================
   // Reporting state: clears first, hardware sets last so they win
   // =====================================================================
   always_comb begin
      next_cfg        = cfg;
      next_low_limit  = low_limit;
      next_high_limit = high_limit;
      next_result     = result;
      next_flag_high  = flag_high;
      next_flag_low   = flag_low;
      next_conv_ready = conv_ready;
      next_int_active = int_active;
      next_int_meta   = INT_I;
      next_int_sync   = int_meta;

      if (cfg_wr) begin
         next_cfg.mode        = REG_WDATA_I[CFG_MODE_LSB +: 2];
         next_cfg.latch       = REG_WDATA_I[CFG_LATCH_BIT];
         next_cfg.polarity    = REG_WDATA_I[CFG_POL_BIT];
         next_cfg.fault_count = REG_WDATA_I[CFG_FC_LSB +: 2];
      end
      if (low_wr) begin
         next_low_limit = REG_WDATA_I;
      end
      if (high_wr) begin
         next_high_limit = REG_WDATA_I;
      end

      if (cfg_rd) begin
         next_conv_ready = 1'b0;
         if (cfg.latch) begin
            next_flag_high  = 1'b0;
            next_flag_low   = 1'b0;
            next_int_active = 1'b0;
         end else if (eoc) begin
            next_int_active = 1'b0;
         end
      end
      if (run_wr) begin
         next_conv_ready = 1'b0;
         if (eoc) begin
            next_int_active = 1'b0;
         end
      end
      // Dropping the latch field releases an interrupt left from latched operation.
      if (cfg_wr && cfg.latch && !REG_WDATA_I[CFG_LATCH_BIT]) begin
         next_int_active = 1'b0;
      end
      if (ALERT_RESP_I && cfg.latch) begin
         next_int_active = 1'b0;
      end

      if (CONV_DONE_I) begin
         next_result     = CONV_RESULT_I;
         next_conv_ready = 1'b1;
         if (eoc) begin
            next_int_active = 1'b1;
         end
      end
      if (trip_high) begin
         next_flag_high  = 1'b1;
         next_int_active = 1'b1;
         if (!cfg.latch) begin
            next_flag_low = 1'b0;
         end
      end
      if (trip_low) begin
         next_flag_low = 1'b1;
         if (cfg.latch) begin
            next_int_active = 1'b1;
         end else begin
            next_flag_high  = 1'b0;
            next_int_active = eoc;
         end
      end

      next_int_oe = next_int_active ^ next_cfg.polarity;
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         cfg        <= RST_CFG;
         low_limit  <= RST_LOW;
         high_limit <= RST_HIGH;
         result     <= RST_RESULT;
         flag_high  <= 1'b0;
         flag_low   <= 1'b0;
         conv_ready <= 1'b0;
         int_active <= 1'b0;
         int_oe     <= RST_POL;
         int_meta   <= 1'b0;
         int_sync   <= 1'b0;
         rdata      <= 16'h0000;
      end else begin
         cfg        <= next_cfg;
         low_limit  <= next_low_limit;
         high_limit <= next_high_limit;
         result     <= next_result;
         flag_high  <= next_flag_high;
         flag_low   <= next_flag_low;
         conv_ready <= next_conv_ready;
         int_active <= next_int_active;
         int_oe     <= next_int_oe;
         int_meta   <= next_int_meta;
         int_sync   <= next_int_sync;
         rdata      <= next_rdata;
      end
   end

   assign REG_RDATA_O = rdata;
   assign INT_O       = 1'b0;
   assign INT_OE_O    = int_oe;

   // =====================================================================
   // Checks
   // =====================================================================
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (RST_I);

   chk_pin_drive_level: assert property (
      INT_OE_O == (int_active ^ cfg.polarity))
      else $error("interrupt pin drive does not match state and polarity");

   chk_ready_on_done: assert property (
      CONV_DONE_I |=> conv_ready ##1 (conv_ready || $past(cfg_rd) || $past(run_wr)))
      else $error("conversion ready not set by completion");

   chk_read_clears_ready: assert property (
      cfg_rd && !CONV_DONE_I |=> !conv_ready)
      else $error("conversion ready survived config read");

   chk_latched_read_clear: assert property (
      cfg_rd && cfg.latch && !CONV_DONE_I |=> !flag_high && !flag_low && !int_active)
      else $error("latched read did not clear flags and interrupt");

   chk_alert_keeps_flags: assert property (
      ALERT_RESP_I && cfg.latch && !CONV_DONE_I && !cfg_rd
      |=> !int_active && $stable(flag_high) && $stable(flag_low))
      else $error("alert response handled wrongly in latched mode");

   chk_alert_ignored: assert property (
      ALERT_RESP_I && !cfg.latch && !CONV_DONE_I && !REG_RD_I && !REG_WR_I
      |=> $stable(int_active))
      else $error("alert response acted on in transparent mode");

   chk_latched_trip: assert property (
      cfg.latch && (trip_high || trip_low)
      |=> int_active && (flag_high == $past(trip_high) || $past(flag_high)))
      else $error("latched trip did not raise interrupt and flag");

   chk_trans_high_trip: assert property (
      trip_high && !cfg.latch |=> int_active && flag_high && !flag_low)
      else $error("transparent high trip wrong");

   chk_trans_low_trip: assert property (
      trip_low && !cfg.latch |=> flag_low && !flag_high && (int_active == $past(eoc)))
      else $error("transparent low trip wrong");

   chk_trans_access_hold: assert property (
      !cfg.latch && !eoc && !CONV_DONE_I && !ALERT_RESP_I && (cfg_rd || cfg_wr)
      |=> $stable(int_active) && $stable(flag_high) && $stable(flag_low))
      else $error("transparent config access changed reporting");

   chk_shutdown_write: assert property (
      cfg_wr && !run_wr && !CONV_DONE_I && !ALERT_RESP_I
      && (REG_WDATA_I[CFG_LATCH_BIT] == cfg.latch)
      |=> $stable(conv_ready) && $stable(int_active) && $stable(flag_high) && $stable(flag_low))
      else $error("shutdown write changed reporting");

   chk_eoc_completion: assert property (
      CONV_DONE_I && eoc |=> int_active)
      else $error("completion in end-of-conversion mode did not activate");

   chk_eoc_read_clear: assert property (
      cfg_rd && eoc && !CONV_DONE_I |=> !int_active)
      else $error("config read in end-of-conversion mode left interrupt active");

   chk_run_write_ready: assert property (
      run_wr && !CONV_DONE_I |=> !conv_ready)
      else $error("run write did not clear conversion ready");

   chk_latched_flag_hold: assert property (
      cfg.latch && !cfg_rd && !trip_high && !trip_low
      |=> $stable(flag_high) && $stable(flag_low))
      else $error("latched flags changed without read or trip");

endmodule : lti_top

`default_nettype wire

// ==== test/lti_host_model.sv ====
// Host side of the open-drain interrupt wire with its pull-up resistor.
`timescale 1ns/100ps
`default_nettype none

module lti_host_model (
   input  wire logic int_oe_i,
   input  wire logic int_o_i,
   output logic      wire_level_o
);
   // The pull-up holds the wire high unless the device pulls it low.
   assign wire_level_o = int_oe_i ? int_o_i : 1'b1;
endmodule : lti_host_model

`default_nettype wire

// ==== test/test_lti_top.sv ====
// Self-checking testbench of the light threshold interrupt logic.
`timescale 1ns/100ps
`default_nettype none

module test_lti_top
   import lti_pkg::*;
;
   typedef struct {
      logic [15:0] cfg;
      logic [15:0] res;
      int          n;
      logic [15:0] flags;
      logic        oe;
   } lti_row_t;

   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, done = 1'b0, alert = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000, res = 16'h0000, rdata, d;
   logic        int_o, int_oe, pin;
   int          num_errors = 0, checked = 0, cycles = 0;
   lti_row_t    rows [10] = '{
      '{16'h0210, 16'h2000, 1, 16'h00c0, 1'b1}, '{16'h0218, 16'h0050, 1, 16'h00a0, 1'b0},
      '{16'h0211, 16'h2000, 1, 16'h0080, 1'b0}, '{16'h0211, 16'h2000, 2, 16'h00c0, 1'b1},
      '{16'h0212, 16'h2000, 3, 16'h0080, 1'b0}, '{16'h0212, 16'h0050, 4, 16'h00a0, 1'b1},
      '{16'h0213, 16'h2000, 8, 16'h00c0, 1'b1}, '{16'h0200, 16'h2000, 1, 16'h00c0, 1'b1},
      '{16'h0200, 16'h0050, 1, 16'h00a0, 1'b0}, '{16'h0208, 16'h2000, 1, 16'h00c0, 1'b0}};

   always #20 clk = ~clk;

   lti_top uut (.CORE_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .CONV_DONE_I(done),
      .CONV_RESULT_I(res), .ALERT_RESP_I(alert), .INT_I(pin), .INT_O(int_o),
      .INT_OE_O(int_oe));

   lti_host_model host (.int_oe_i(int_oe), .int_o_i(int_o), .wire_level_o(pin));

   // =====================================================================
   // Bus and event tasks
   // =====================================================================
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic conv(input logic [15:0] r, input int n);
      repeat (n) begin
         @(posedge clk);
         done <= 1'b1;
         res  <= r;
      end
      @(posedge clk);
      done <= 1'b0;
      #1;
   endtask : conv

   task automatic pulse_alert();
      @(posedge clk);
      alert <= 1'b1;
      @(posedge clk);
      alert <= 1'b0;
      #1;
   endtask : pulse_alert

   task automatic oe_is(input logic e);
      chk({15'h0000, int_oe}, {15'h0000, e});
   endtask : oe_is

   task automatic setup(input logic [15:0] cfg);
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wr_reg(HIGH_ADDR, 16'h1000); // High limit kept above low limit.
      wr_reg(LOW_ADDR, 16'h0100);
      wr_reg(CFG_ADDR, cfg);
   endtask : setup

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         conclude();
      end
   end

   // =====================================================================
   // Test sequence
   // =====================================================================
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      #1;
      oe_is(1'b0);
      rd_reg(CFG_ADDR);
      chk(d & 16'h06ff, 16'h0010);
      @(posedge clk);
      #1;
      chk(rdata, 16'h0000);
      rd_reg(LOW_ADDR);
      chk(d, 16'h0000);
      rd_reg(HIGH_ADDR);
      chk(d, 16'hffff);
      wr_reg(8'h07, 16'hffff);
      rd_reg(8'h07);
      chk(d, 16'h0000);
      wr_reg(RESULT_ADDR, 16'h1234);
      rd_reg(RESULT_ADDR);
      chk(d, 16'h0000);
      rd_reg(CFG_ADDR);
      chk(d & 16'h0100, 16'h0100);
      $display("reset test done");
      foreach (rows[i]) begin
         setup(rows[i].cfg);
         conv(rows[i].res, rows[i].n);
         oe_is(rows[i].oe);
         rd_reg(CFG_ADDR);
         chk(d & 16'h00e0, rows[i].flags);
         $display("row %0d done", i);
      end
      setup(16'h0210);
      conv(16'h0800, 1);
      rd_reg(CFG_ADDR);
      chk(d & 16'h00e0, 16'h0080);
      rd_reg(CFG_ADDR);
      chk(d & 16'h00e0, 16'h0000);
      rd_reg(RESULT_ADDR);
      chk(d, 16'h0800);
      conv(16'h2000, 1);
      repeat (2) @(posedge clk);
      rd_reg(CFG_ADDR);
      chk(d & 16'h01e0, 16'h00c0);
      oe_is(1'b0);
      rd_reg(CFG_ADDR);
      chk(d & 16'h00e0, 16'h0000);
      $display("read clear test done");
      setup(16'h0210);
      conv(16'h2000, 1);
      pulse_alert();
      oe_is(1'b0);
      rd_reg(CFG_ADDR);
      chk(d & 16'h00e0, 16'h00c0);
      setup(16'h0210);
      conv(16'h2000, 1);
      wr_reg(CFG_ADDR, 16'h0010);
      oe_is(1'b1);
      wr_reg(CFG_ADDR, 16'h0210);
      oe_is(1'b1);
      rd_reg(CFG_ADDR);
      chk(d & 16'h00e0, 16'h0040);
      conv(16'h0800, 1);
      wr_reg(CFG_ADDR, 16'h0010);
      rd_reg(CFG_ADDR);
      chk(d & 16'h00e0, 16'h0080);
      $display("alert and write test done");
      setup(16'h0200);
      conv(16'h2000, 1);
      pulse_alert();
      oe_is(1'b1);
      rd_reg(CFG_ADDR);
      wr_reg(CFG_ADDR, 16'h0200);
      oe_is(1'b1);
      rd_reg(CFG_ADDR);
      chk(d & 16'h00e0, 16'h0040);
      $display("transparent test done");
      setup(16'h0210);
      wr_reg(LOW_ADDR, 16'hc000);
      wr_reg(HIGH_ADDR, 16'hffff);
      conv(16'hc100, 1);
      oe_is(1'b1);
      rd_reg(CFG_ADDR);
      oe_is(1'b0);
      conv(16'hc100, 1);
      wr_reg(CFG_ADDR, 16'h0210);
      oe_is(1'b0);
      conv(16'hc100, 1);
      wr_reg(CFG_ADDR, 16'h0010);
      oe_is(1'b1);
      wr_reg(LOW_ADDR, 16'h0000);
      wr_reg(CFG_ADDR, 16'h0200);
      oe_is(1'b0);
      $display("end of conversion test done");
      setup(16'h0200);
      wr_reg(LOW_ADDR, 16'hc000);
      wr_reg(HIGH_ADDR, 16'hffff);
      conv(16'hc100, 1);
      oe_is(1'b1);
      rd_reg(CFG_ADDR);
      oe_is(1'b0);
      conv(16'h0050, 1);
      oe_is(1'b1);
      pulse_alert();
      oe_is(1'b1);
      rd_reg(CFG_ADDR);
      chk(d & 16'h00e0, 16'h00a0);
      $display("transparent end of conversion test done");
      setup(16'h0211);
      conv(16'h2000, 1);
      conv(16'h0050, 1);
      conv(16'h2000, 1);
      oe_is(1'b0);
      conv(16'h0800, 1);
      conv(16'h2000, 1);
      oe_is(1'b0);
      conv(16'h2000, 1);
      oe_is(1'b1);
      $display("counter restart test done");
      conclude();
   end
endmodule : test_lti_top

`default_nettype wire
